// ### core/spd_link.sv
`timescale 1ns/1ps
// ****************************************
// serial link shifter
// ****************************************
module spd_link (
	input  wire logic        serial_clock,
	input  wire logic        link_rst_n,
	input  wire logic        frame_rst_n,
	input  wire logic        serial_command_input,
	input  wire logic [7:0]  read_byte,
	output logic      [23:0] header,
	output logic      [31:0] command,
	output logic             header_toggle,
	output logic             command_toggle,
	output logic             serial_result_output
);
	logic [4:0]  cnt;
	logic [30:0] shift_in;
	logic [6:0]  shift_out;
	wire  [4:0]  next_cnt = cnt + 5'h01;

	// ****************************************
	// frame counter and input shift
	// ****************************************
	// rising edge sampling
	always_ff @(posedge serial_clock or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			cnt      <= 5'h00;
			shift_in <= '0;
		end else begin
			cnt      <= next_cnt;
			shift_in <= {shift_in[29:0], serial_command_input};
		end
	end

	always_ff @(posedge serial_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			header         <= '0;
			command        <= '0;
			header_toggle  <= 1'b0;
			command_toggle <= 1'b0;
		end else begin
			if (frame_rst_n && cnt == spd_pkg::HDR_LAST) begin
				header        <= {shift_in[22:0], serial_command_input};
				header_toggle <= ~header_toggle;
			end
			if (frame_rst_n && cnt == spd_pkg::CMD_LAST) begin
				command        <= {shift_in, serial_command_input};
				command_toggle <= ~command_toggle;
			end
		end
	end

	// ****************************************
	// output shift
	// ****************************************
	// falling edge shifting
	always_ff @(negedge serial_clock or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			shift_out            <= '0;
			serial_result_output <= 1'b0;
		end else if (cnt == spd_pkg::HDR_CNT) begin
			shift_out            <= read_byte[6:0];
			serial_result_output <= read_byte[7];
		end else begin
			shift_out            <= {shift_out[5:0], 1'b0};
			serial_result_output <= shift_out[6];
		end
	end

	// ****************************************
	// checks
	// ****************************************
	cmd_sample_a: assert property (
		@(posedge serial_clock) disable iff (!frame_rst_n)
		cnt == spd_pkg::CMD_LAST |=> command[0] == $past(serial_command_input)
	) else $error("command bit not sampled on rising edge");

	out_shift_a: assert property (
		@(negedge serial_clock) disable iff (!frame_rst_n)
		cnt == spd_pkg::HDR_CNT |=> serial_result_output == $past(read_byte[7])
	) else $error("result msb not shifted on falling edge");

endmodule

// ### core/spd_pkg.sv
// ****************************************
// serial programming decoder constants
// ****************************************
package spd_pkg;

	// ****************************************
	// opcode fields
	// ****************************************
	localparam logic [7:0] OPC_PREFIX_B1 = 8'hac;
	localparam logic [7:0] OPC_ENABLE_B2 = 8'h53;
	localparam logic [2:0] OPC_ERASE_B2  = 3'h4;
	localparam logic [2:0] OPC_LOCK_B2   = 3'h7;
	localparam logic [3:0] OPC_RD_PROG   = 4'h2;
	localparam logic [3:0] OPC_WR_PROG   = 4'h4;
	localparam logic [7:0] OPC_RD_EE     = 8'ha0;
	localparam logic [7:0] OPC_WR_EE     = 8'hc0;
	localparam logic [7:0] OPC_RD_IO     = 8'hb0;
	localparam logic [7:0] OPC_WR_IO     = 8'hd0;
	localparam logic [7:0] OPC_SIG       = 8'h30;

	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int         HSEL_BIT       = 3;
	localparam int         LOCK_ONE_BIT   = 1;
	localparam int         LOCK_TWO_BIT   = 2;
	localparam logic [1:0] LOCK_RESET     = 2'h3;
	localparam logic [7:0] RESULT_REFUSED = 8'hff;

	// ****************************************
	// bit counts of a frame
	// ****************************************
	localparam logic [4:0] HDR_LAST = 5'h17;
	localparam logic [4:0] HDR_CNT  = 5'h18;
	localparam logic [4:0] CMD_LAST = 5'h1f;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {SPD_SP_PROG, SPD_SP_EE, SPD_SP_IO} spd_space_t;

	typedef enum logic [3:0] {
		SPD_OP_NONE, SPD_OP_ENABLE, SPD_OP_ERASE, SPD_OP_RD_PROG, SPD_OP_WR_PROG,
		SPD_OP_RD_EE, SPD_OP_WR_EE, SPD_OP_LOCK, SPD_OP_RD_IO, SPD_OP_WR_IO, SPD_OP_SIG
	} spd_op_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic       erase;
		spd_space_t space;
		logic       hi;
		logic [9:0] addr;
		logic [7:0] data;
	} spd_mem_req_t;

endpackage

// ### core/spd_top.sv
`timescale 1ns/1ps
// Operation
// - enable command AC 53 xx xx unlocks programming while reset pin low
// - program read 0010H000, 000000aa, b; byte returned in fourth byte
// - program write 0100H000, word address a:b, data byte stored to half
// - byte select bit 0 picks low byte, 1 picks high byte
// - eeprom read A0 00 then seven-bit address; stored byte shifted out
// - eeprom write C0 00, seven-bit address, data byte stored there
// - lock write AC 111xx21x; zero in a position programs that lock
// - io read B0 00, six-bit address; location returned in fourth byte
// - io write D0 00, six-bit address, following data byte written
// - serial input sampled on rising serial clock edge
// - serial output shifted on falling serial clock edge
// - three signature bytes 0 to 2, picked by low address bits
// - lock one blocks program and eeprom writes; both locks also block those reads; io is not locked
module spd_top #(
	parameter logic [7:0] SIG_BYTE0 = 8'h5a, // arbitrary identity value
	parameter logic [7:0] SIG_BYTE1 = 8'h01, // arbitrary identity value
	parameter logic [7:0] SIG_BYTE2 = 8'h02  // arbitrary identity value
) (
	input  wire logic         clock,
	input  wire logic         nrst,
	input  wire logic         serial_clock,
	input  wire logic         serial_command_input,
	input  wire logic         external_reset_low_pin,
	input  wire logic [7:0]   mem_rdata,
	output logic              serial_result_output,
	output spd_pkg::spd_mem_req_t mem_req,
	output logic [1:0]        lock_state,
	output logic              programming_enabled
);

	// ****************************************
	// reset release
	// ****************************************
	logic [1:0] rst_sync;
	wire        rst_n = rst_sync[1];

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	// ****************************************
	// link side
	// ****************************************
	logic [23:0] header;
	logic [31:0] command;
	logic        header_toggle;
	logic        command_toggle;
	logic [7:0]  result;
	wire         frame_rst_n = rst_n & ~external_reset_low_pin;

	spd_link u_link (
		.serial_clock         (serial_clock),
		.link_rst_n           (rst_n),
		.frame_rst_n          (frame_rst_n),
		.serial_command_input (serial_command_input),
		.read_byte            (result),
		.header               (header),
		.command              (command),
		.header_toggle        (header_toggle),
		.command_toggle       (command_toggle),
		.serial_result_output (serial_result_output)
	);

	// ****************************************
	// crossings
	// ****************************************
	wire  [2:0] sync_in = {external_reset_low_pin, command_toggle, header_toggle};
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic [2:0] sync3;
	logic [2:0] level;
	wire  [2:0] agree = ~(sync2 ^ sync3);
	wire  [2:0] change = agree & (sync3 ^ level);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					sync1[gi] <= (gi == 2);
					sync2[gi] <= (gi == 2);
					sync3[gi] <= (gi == 2);
					level[gi] <= (gi == 2);
				end else begin
					sync1[gi] <= sync_in[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					if (change[gi]) begin
						level[gi] <= sync3[gi];
					end
				end
			end
		end
	endgenerate

	wire hdr_evt  = change[0];
	wire cmd_evt  = change[1];
	wire pin_high = level[2];

	// ****************************************
	// decoding
	// ****************************************
	function automatic spd_pkg::spd_op_t decode_op(input logic [23:0] h);
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] b3;
		b1 = h[23:16];
		b2 = h[15:8];
		b3 = h[7:0];
		decode_op = spd_pkg::SPD_OP_NONE;
		if (b1 == spd_pkg::OPC_PREFIX_B1 && b2 == spd_pkg::OPC_ENABLE_B2) begin
			decode_op = spd_pkg::SPD_OP_ENABLE;
		end else if (b1 == spd_pkg::OPC_PREFIX_B1 && b2[7:5] == spd_pkg::OPC_ERASE_B2) begin
			decode_op = spd_pkg::SPD_OP_ERASE;
		end else if (b1 == spd_pkg::OPC_PREFIX_B1 && b2[7:5] == spd_pkg::OPC_LOCK_B2) begin
			decode_op = spd_pkg::SPD_OP_LOCK;
		end else if (b1[7:4] == spd_pkg::OPC_RD_PROG && b1[2:0] == 3'h0
				&& b2[7:2] == 6'h00) begin
			decode_op = spd_pkg::SPD_OP_RD_PROG;
		end else if (b1[7:4] == spd_pkg::OPC_WR_PROG && b1[2:0] == 3'h0
				&& b2[7:2] == 6'h00) begin
			decode_op = spd_pkg::SPD_OP_WR_PROG;
		end else if (b1 == spd_pkg::OPC_RD_EE && b2 == 8'h00) begin
			decode_op = spd_pkg::SPD_OP_RD_EE;
		end else if (b1 == spd_pkg::OPC_WR_EE && b2 == 8'h00) begin
			decode_op = spd_pkg::SPD_OP_WR_EE;
		end else if (b1 == spd_pkg::OPC_RD_IO && b2 == 8'h00 && b3[7:6] == 2'h0) begin
			decode_op = spd_pkg::SPD_OP_RD_IO;
		end else if (b1 == spd_pkg::OPC_WR_IO && b2 == 8'h00 && b3[7:6] == 2'h0) begin
			decode_op = spd_pkg::SPD_OP_WR_IO;
		end else if (b1 == spd_pkg::OPC_SIG && b2[7:5] == 3'h0) begin
			decode_op = spd_pkg::SPD_OP_SIG;
		end
	endfunction

	function automatic logic [7:0] sig_byte(input logic [1:0] idx);
		case (idx)
			2'h0: sig_byte = SIG_BYTE0;
			2'h1: sig_byte = SIG_BYTE1;
			2'h2: sig_byte = SIG_BYTE2;
			default: sig_byte = spd_pkg::RESULT_REFUSED;
		endcase
	endfunction

	wire spd_pkg::spd_op_t hdr_op = decode_op(header);
	wire spd_pkg::spd_op_t cmd_op = decode_op(command[31:8]);
	wire spd_pkg::spd_op_t op     = hdr_evt ? hdr_op : cmd_op;
	wire [23:0]            src    = hdr_evt ? header : command[31:8];
	wire [7:0]             b1     = src[23:16];
	wire [7:0]             b2     = src[15:8];
	wire [7:0]             b3     = src[7:0];

	// ****************************************
	// permissions
	// ****************************************
	logic [1:0] lock;
	logic       enabled;
	wire        allowed = enabled & ~pin_high;
	wire        wr_ok   = allowed & lock[0];
	wire        rd_ok   = allowed & (lock[0] | lock[1]);

	wire is_prog = op == spd_pkg::SPD_OP_RD_PROG || op == spd_pkg::SPD_OP_WR_PROG;
	wire is_ee   = op == spd_pkg::SPD_OP_RD_EE || op == spd_pkg::SPD_OP_WR_EE;
	wire is_io   = op == spd_pkg::SPD_OP_RD_IO || op == spd_pkg::SPD_OP_WR_IO;

	// ****************************************
	// request build
	// ****************************************
	// read, write, erase, lock and enable issue
	wire rd_mem = hdr_evt && ((op == spd_pkg::SPD_OP_RD_PROG && rd_ok)
		|| (op == spd_pkg::SPD_OP_RD_EE && rd_ok)
		|| (op == spd_pkg::SPD_OP_RD_IO && allowed));
	wire rd_sig = hdr_evt && op == spd_pkg::SPD_OP_SIG && allowed;
	wire wr_mem = cmd_evt && ((op == spd_pkg::SPD_OP_WR_PROG && wr_ok)
		|| (op == spd_pkg::SPD_OP_WR_EE && wr_ok)
		|| (op == spd_pkg::SPD_OP_WR_IO && allowed));
	wire do_erase = cmd_evt && op == spd_pkg::SPD_OP_ERASE && allowed;
	wire do_lock  = cmd_evt && op == spd_pkg::SPD_OP_LOCK && allowed;
	wire do_enable = cmd_evt && op == spd_pkg::SPD_OP_ENABLE && !pin_high;

	wire spd_pkg::spd_space_t next_space = is_prog ? spd_pkg::SPD_SP_PROG
		: (is_ee ? spd_pkg::SPD_SP_EE : spd_pkg::SPD_SP_IO);
	wire [9:0] next_addr = is_prog ? {b2[1:0], b3}
		: (is_io ? {4'h0, b3[5:0]} : {3'h0, b3[6:0]});
	wire [1:0] next_lock = do_erase ? spd_pkg::LOCK_RESET
		: (do_lock ? lock & {b2[spd_pkg::LOCK_TWO_BIT], b2[spd_pkg::LOCK_ONE_BIT]} : lock);

	spd_pkg::spd_mem_req_t next_req;
	assign next_req = '{rd: rd_mem, wr: wr_mem, erase: do_erase, space: next_space,
		hi: b1[spd_pkg::HSEL_BIT], addr: next_addr, data: command[7:0]};

	// ****************************************
	// state
	// ****************************************
	logic rd_wait;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mem_req <= '0;
			rd_wait <= 1'b0;
		end else begin
			mem_req <= next_req;
			rd_wait <= mem_req.rd;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			result <= spd_pkg::RESULT_REFUSED;
		end else if (rd_wait) begin
			result <= mem_rdata;
		end else if (rd_sig) begin
			result <= sig_byte(b3[1:0]);
		end else if (hdr_evt) begin
			result <= spd_pkg::RESULT_REFUSED;
		end
	end

	wire next_enabled = do_enable | (enabled & ~pin_high & ~do_erase);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			enabled <= 1'b0;
			lock    <= spd_pkg::LOCK_RESET;
		end else begin
			enabled <= next_enabled;
			lock    <= next_lock;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lock_state          <= spd_pkg::LOCK_RESET;
			programming_enabled <= 1'b0;
		end else begin
			lock_state          <= next_lock;
			programming_enabled <= next_enabled;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	enable_set_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		cmd_evt && cmd_op == spd_pkg::SPD_OP_ENABLE && !pin_high |=> programming_enabled
	) else $error("enable command did not enable programming");

	prog_read_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		hdr_evt && hdr_op == spd_pkg::SPD_OP_RD_PROG && rd_ok
		|=> mem_req.rd && mem_req.space == spd_pkg::SPD_SP_PROG
			&& mem_req.addr == {$past(header[9:8]), $past(header[7:0])}
			##2 result == $past(mem_rdata)
	) else $error("program read not issued or returned");

	prog_write_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		cmd_evt && cmd_op == spd_pkg::SPD_OP_WR_PROG && wr_ok
		|=> mem_req.wr && mem_req.data == $past(command[7:0])
			&& mem_req.addr == $past(command[17:8])
	) else $error("program write not issued");

	byte_sel_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		(mem_req.rd || mem_req.wr) && mem_req.space == spd_pkg::SPD_SP_PROG
		|-> mem_req.hi == (mem_req.rd ? $past(header[19]) : $past(command[27]))
	) else $error("byte select wrong");

	ee_read_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		hdr_evt && hdr_op == spd_pkg::SPD_OP_RD_EE && rd_ok
		|=> mem_req.rd && mem_req.space == spd_pkg::SPD_SP_EE
			&& mem_req.addr == {3'h0, $past(header[6:0])}
	) else $error("eeprom read not issued");

	ee_write_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		cmd_evt && cmd_op == spd_pkg::SPD_OP_WR_EE && wr_ok
		|=> mem_req.wr && mem_req.space == spd_pkg::SPD_SP_EE
			&& mem_req.addr == {3'h0, $past(command[14:8])}
	) else $error("eeprom write not issued");

	lock_write_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		cmd_evt && cmd_op == spd_pkg::SPD_OP_LOCK && allowed
		|=> lock_state == ($past(lock) & {$past(command[18]), $past(command[17])})
	) else $error("lock write wrong");

	io_read_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		hdr_evt && hdr_op == spd_pkg::SPD_OP_RD_IO && allowed
		|=> mem_req.rd && mem_req.space == spd_pkg::SPD_SP_IO
			&& mem_req.addr == {4'h0, $past(header[5:0])}
	) else $error("io read not issued");

	io_write_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		cmd_evt && cmd_op == spd_pkg::SPD_OP_WR_IO && allowed
		|=> mem_req.wr && mem_req.space == spd_pkg::SPD_SP_IO
	) else $error("io write not issued");

	sig_read_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		hdr_evt && hdr_op == spd_pkg::SPD_OP_SIG && allowed
		|=> result == sig_byte($past(header[1:0]))
	) else $error("signature byte wrong");

	lock_block_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		(mem_req.wr && mem_req.space != spd_pkg::SPD_SP_IO |-> $past(lock[0]))
		and (mem_req.rd && mem_req.space != spd_pkg::SPD_SP_IO |-> $past(lock != 2'h0))
	) else $error("locked access passed");

	erase_drop_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		mem_req.erase |-> !programming_enabled && lock_state == spd_pkg::LOCK_RESET
	) else $error("erase left programming enabled");

	ignore_bad_a: assert property (
		@(posedge clock) disable iff (!rst_n)
		cmd_evt && cmd_op == spd_pkg::SPD_OP_NONE
		|=> !mem_req.wr && !mem_req.erase && $stable(lock_state)
	) else $error("unknown command changed state");

endmodule

// ### sim/spd_prog_model.sv
`timescale 1ns/1ps
// ****************************************
// programmer model
// ****************************************
module spd_prog_model #(
	parameter real LOW_NS  = 24.0,
	parameter real HIGH_NS = 64.0
) (
	output logic      serial_clock,
	output logic      serial_command_input,
	output logic      external_reset_low_pin,
	input  wire logic serial_result_output
);
	initial begin
		serial_clock = 1'b0;
		serial_command_input = 1'b0;
		external_reset_low_pin = 1'b0;
	end

	task automatic frame(input logic [31:0] cmd, output logic [7:0] rd);
		rd = 8'h00;
		for (int i = 31; i >= 0; i--) begin
			serial_command_input = cmd[i];
			#(LOW_NS);
			if (i < 8) rd[i] = serial_result_output;
			serial_clock = 1'b1;
			#(HIGH_NS);
			serial_clock = 1'b0;
		end
		serial_command_input = ~cmd[0];
		#(LOW_NS);
	endtask

	task automatic pulse_pin();
		external_reset_low_pin = 1'b1;
		#(HIGH_NS);
		external_reset_low_pin = 1'b0;
		#(HIGH_NS);
	endtask
endmodule

// ### sim/spd_tb.sv
`timescale 1ns/1ps
// ****************************************
// bench top
// ****************************************
module serial_programming_command_decoder_tb_top;
	logic                  clock;
	logic                  nrst;
	logic                  serial_clock;
	logic                  serial_command_input;
	logic                  external_reset_low_pin;
	logic [7:0]            mem_rdata;
	logic                  serial_result_output;
	spd_pkg::spd_mem_req_t mem_req;
	spd_pkg::spd_mem_req_t last_wr;
	logic [1:0]            lock_state;
	logic                  programming_enabled;
	logic [7:0]            store [logic [12:0]];
	logic [7:0]            r;
	int                    num_errors;
	int                    n_tests;
	int                    n_wr = 0;
	int                    n_er = 0;
	wire logic [12:0]      key = {mem_req.space, mem_req.hi, mem_req.addr};

	spd_top DUT (
		.clock                  (clock),
		.nrst                   (nrst),
		.serial_clock           (serial_clock),
		.serial_command_input   (serial_command_input),
		.external_reset_low_pin (external_reset_low_pin),
		.mem_rdata              (mem_rdata),
		.serial_result_output   (serial_result_output),
		.mem_req                (mem_req),
		.lock_state             (lock_state),
		.programming_enabled    (programming_enabled)
	);

	spd_prog_model prog (
		.serial_clock           (serial_clock),
		.serial_command_input   (serial_command_input),
		.external_reset_low_pin (external_reset_low_pin),
		.serial_result_output   (serial_result_output)
	);

	// ****************************************
	// clock and memory model
	// ****************************************
	initial clock = 1'b0;
	always #2 clock = ~clock;

	always @(posedge clock) begin
		if (!nrst) begin
			mem_rdata <= 8'h00;
		end else if (mem_req.rd) begin
			mem_rdata <= store.exists(key) ? store[key] : 8'hff;
		end else begin
			mem_rdata <= ~mem_rdata;
		end
		if (mem_req.wr) begin
			store[key] = mem_req.data;
			last_wr <= mem_req;
			n_wr++;
		end
		if (mem_req.erase) begin
			store.delete();
			n_er++;
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic xfer(input logic [31:0] c);
		prog.frame(c, r);
		#100;
	endtask

	task automatic chk_wr(input logic [1:0] sp, input logic h, input logic [9:0] a,
		input logic [7:0] d);
		check({11'h0, last_wr.space, last_wr.hi, last_wr.addr, last_wr.data},
			{11'h0, sp, h, a, d});
	endtask

	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_before_enable();
		xfer(32'hc0_00_05_aa);
		check(32'(n_wr), 32'h0);
		xfer(32'ha0_00_05_00);
		check(r, 8'hff);
		xfer(32'hac_53_00_00);
		check(programming_enabled, 1'b1);
	endtask

	task automatic t_prog();
		logic [7:0] d [2];
		d[0] = 8'ha5;
		d[1] = 8'h3c;
		for (int h = 0; h < 2; h++) begin
			xfer({4'h4, h[0], 3'h0, 8'h03, 8'h5c, d[h]});
			chk_wr(2'h0, h[0], 10'h35c, d[h]);
		end
		for (int h = 0; h < 2; h++) begin
			xfer({4'h2, h[0], 3'h0, 8'h03, 8'h5c, 8'h00});
			check(r, d[h]);
		end
	endtask

	task automatic t_ee_io();
		xfer(32'hc0_00_ff_96);
		chk_wr(2'h1, 1'b0, 10'h07f, 8'h96);
		xfer(32'ha0_00_7f_00);
		check(r, 8'h96);
		xfer(32'hd0_00_3f_81);
		chk_wr(2'h2, 1'b0, 10'h03f, 8'h81);
		xfer(32'hb0_00_3f_00);
		check(r, 8'h81);
	endtask

	task automatic t_sig();
		logic [7:0] e [4];
		e = '{8'h5a, 8'h01, 8'h02, 8'hff};
		for (int i = 0; i < 4; i++) begin
			xfer({8'h30, 8'h00, 6'h0, i[1:0], 8'h00});
			check(r, e[i]);
		end
	endtask

	task automatic t_unknown();
		int n0;
		n0 = n_wr;
		xfer(32'hff_ff_ff_ff);
		xfer(32'h00_00_00_00);
		check(32'(n_wr), 32'(n0));
		check({lock_state, programming_enabled}, 3'b111);
	endtask

	task automatic t_lock();
		int n0;
		n0 = n_wr;
		xfer(32'hac_fd_00_00);
		check(lock_state, 2'b10);
		xfer(32'hc0_00_10_55);
		check(32'(n_wr), 32'(n0));
		xfer(32'h20_03_5c_00);
		check(r, 8'ha5);
		xfer(32'hac_fb_00_00);
		check(lock_state, 2'b00);
		xfer(32'h20_03_5c_00);
		check(r, 8'hff);
	endtask

	task automatic t_erase();
		int n0;
		n0 = n_er;
		xfer(32'hac_80_00_00);
		#200;
		check(32'(n_er), 32'(n0 + 1));
		check({lock_state, programming_enabled}, 3'b110);
		prog.pulse_pin();
		xfer(32'hac_53_00_00);
		check(programming_enabled, 1'b1);
		xfer(32'h28_03_5c_00);
		check(r, 8'hff);
	endtask

	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		nrst = 1'b0;
		num_errors = 0;
		n_tests = 0;
		repeat (10) @(posedge clock);
		#1 nrst = 1'b1;
		repeat (20) @(posedge clock);
		t_before_enable();
		t_prog();
		t_ee_io();
		t_sig();
		t_unknown();
		t_lock();
		t_erase();
		end_of_test();
	end

	initial begin
		#150000;
		num_errors++;
		end_of_test();
	end
endmodule
